// File: cpuex_pkg.sv
// Purpose: constants shared by the exception acceptance block
// Assumes: 32-bit core, 12-bit event codes, AXI4-Lite register access
// Notes: event codes, vector offsets, register map and field positions
package cpuex_pkg;
   localparam int CPUEX_CODE_W = 12;
   localparam logic [11:0] CPUEX_EV_POWER_ON = 12'h000;
   localparam logic [11:0] CPUEX_EV_MANUAL = 12'h020;
   localparam logic [11:0] CPUEX_EV_TLB_LOAD = 12'h040;
   localparam logic [11:0] CPUEX_EV_TLB_STORE = 12'h060;
   localparam logic [11:0] CPUEX_EV_PAGE_WRITE = 12'h080;
   localparam logic [11:0] CPUEX_EV_PROT_LOAD = 12'h0A0;
   localparam logic [11:0] CPUEX_EV_PROT_STORE = 12'h0C0;
   localparam logic [11:0] CPUEX_EV_ADDR_LOAD = 12'h0E0;
   localparam logic [11:0] CPUEX_EV_ADDR_STORE = 12'h100;
   localparam logic [11:0] CPUEX_EV_TRAP = 12'h160;
   localparam logic [11:0] CPUEX_EV_RESERVED_OP = 12'h180;
   localparam logic [11:0] CPUEX_EV_ILLEGAL_SLOT = 12'h1A0;
   localparam logic [11:0] CPUEX_EV_NMI = 12'h1C0;
   localparam logic [11:0] CPUEX_EV_USER_BREAK = 12'h1E0;
   localparam logic [11:0] CPUEX_EV_EXT_BASE = 12'h200;
   localparam logic [11:0] CPUEX_EV_PERIPH_BASE = 12'h400;
   localparam logic [11:0] CPUEX_EV_STEP = 12'h020;
   localparam int CPUEX_PERIPH_N = 14;
   localparam logic [3:0] CPUEX_LEVEL_NONE = 4'hF;
   localparam logic [31:0] CPUEX_RESET_VECTOR = 32'hA0000000;
   localparam logic [31:0] CPUEX_OFS_TLB_MISS = 32'h00000400;
   localparam logic [31:0] CPUEX_OFS_GENERAL = 32'h00000100;
   localparam logic [31:0] CPUEX_OFS_INTERRUPT = 32'h00000600;
   localparam logic [31:0] CPUEX_VBR_RESET = 32'h00000000;
   // Status word fields
   localparam int CPUEX_SR_PRIV = 30;
   localparam int CPUEX_SR_BANK = 29;
   localparam int CPUEX_SR_BLOCK = 28;
   localparam logic [3:0] CPUEX_SR_IMASK_RESET = 4'hF;
   localparam int CPUEX_SR_IMASK_LSB = 4;
   localparam logic [31:0] CPUEX_SR_RESET = 32'h700000F0;
   // Register map, byte addresses
   localparam logic [7:0] CPUEX_A_TRAP_IMM = 8'h00;
   localparam logic [7:0] CPUEX_A_EXC_EVENT = 8'h04;
   localparam logic [7:0] CPUEX_A_INT_EVENT = 8'h08;
   localparam logic [7:0] CPUEX_A_STATUS = 8'h0C;
   localparam logic [7:0] CPUEX_A_SAVED_PC = 8'h10;
   localparam logic [7:0] CPUEX_A_SAVED_ST = 8'h14;
   localparam logic [7:0] CPUEX_A_VBASE = 8'h18;
   localparam logic [7:0] CPUEX_A_PC = 8'h1C;
   localparam logic [1:0] CPUEX_RESP_OKAY = 2'b00;
   localparam logic [1:0] CPUEX_RESP_SLVERR = 2'b10;
   // General exception sources, index equals program-stage order
   localparam int CPUEX_GEN_N = 13;
endpackage

// File: cpuex_gen_select.sv
// Purpose: pick the first general exception of one instruction
// Assumes: request vector ordered by exception order, bit 0 first
// Notes: purely combinational
module cpuex_gen_select
   import cpuex_pkg::*;
(
   input wire logic [CPUEX_GEN_N-1:0] req,
   input wire logic is_write,
   output logic any,
   output logic [11:0] code,
   output logic tlb_miss,
   output logic completion
);
   // Order: iaddr, itlbmiss, itlbinv, iprot, decode(trap/resv/slot),
   // daddr, dtlbmiss, dtlbinv, dprot, pagewrite, user break
   // Bits: 0 ia 1 im 2 ii 3 ip 4 resv 5 slot 6 trap 7 da 8 dm 9 di
   // 10 dp 11 pw 12 ub
   always_comb begin
      any = |req;
      code = 12'h000;
      tlb_miss = 1'b0;
      completion = 1'b0;
      for (int i = CPUEX_GEN_N - 1; i >= 0; i--) begin
         if (req[i]) begin
            tlb_miss = (i == 1) || (i == 8);
            completion = (i == 6) || (i == 12);
            unique case (i)
               0, 7: code = is_write ? CPUEX_EV_ADDR_STORE : CPUEX_EV_ADDR_LOAD;
               1, 2, 8, 9: code = is_write ? CPUEX_EV_TLB_STORE : CPUEX_EV_TLB_LOAD;
               3, 10: code = is_write ? CPUEX_EV_PROT_STORE : CPUEX_EV_PROT_LOAD;
               4: code = CPUEX_EV_RESERVED_OP;
               5: code = CPUEX_EV_ILLEGAL_SLOT;
               6: code = CPUEX_EV_TRAP;
               11: code = CPUEX_EV_PAGE_WRITE;
               default: code = CPUEX_EV_USER_BREAK;
            endcase
         end
      end
   end
endmodule

// File: cpuex_int_select.sv
// Purpose: pick the interrupt to take and its event code
// Assumes: controller has already ranked external against peripheral
// Notes: purely combinational
module cpuex_int_select
   import cpuex_pkg::*;
(
   input wire logic nmi,
   input wire logic [3:0] interrupt_level_inputs,
   input wire logic [CPUEX_PERIPH_N-1:0] periph_req,
   input wire logic periph_first,
   output logic any,
   output logic [11:0] code
);
   logic ext_req;
   logic per_req;
   logic [11:0] ext_code;
   logic [11:0] per_code;
   always_comb begin
      ext_req = interrupt_level_inputs != CPUEX_LEVEL_NONE;
      ext_code = CPUEX_EV_EXT_BASE + {3'b000, interrupt_level_inputs, 5'b00000};
      per_req = |periph_req;
      per_code = CPUEX_EV_PERIPH_BASE;
      for (int i = CPUEX_PERIPH_N - 1; i >= 0; i--) begin
         if (periph_req[i]) begin
            per_code = CPUEX_EV_PERIPH_BASE + 12'(i * 32);
         end
      end
      any = nmi | ext_req | per_req;
      if (nmi) begin
         code = CPUEX_EV_NMI;
      end else if (per_req && (periph_first || !ext_req)) begin
         code = per_code;
      end else begin
         code = ext_code;
      end
   end
endmodule

// File: cpuex_core.sv
// Purpose: exception acceptance, event coding and return for the core
// Assumes: pipeline reports decode-stage exceptions with boundary strobe
// Notes: registers reached over AXI4-Lite
// Summary of operation
// - Rank reset, exception, NMI, interrupt in order.
// - Interrupt controller decides external versus peripheral order.
// - Power-on and manual reset share top rank.
// - Earlier instruction exceptions are taken first.
// - Decode exceptions exclusive, equal priority.
// - Take exceptions only at boundaries; resets anytime.
// - Nothing taken between branch and delay slot.
// - Retry exception in slot taken before branch.
// - Completion exception taken after branch executes.
// - Write code into proper event register.
// - Trap captures its 8-bit immediate.
// - Memory access exception codes.
// - Instruction exception codes.
// - NMI and level interrupt codes.
// - Peripheral codes from 400 to 5A0.
// - Reserved codes never generated.
// - Block bit clear accepts everything.
// - Exception while blocked resets core state.
// - Interrupt while blocked stays pending.
// - Return restores pc and status word.
// - Save pc and status, set three bits.
// - Interrupts vector to base plus 600.
// - Miss to base plus 400, else 100.
// - Reset writes 000 or 020, starts A0000000.
module cpuex_core
   import cpuex_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic manual_reset,
   input wire logic boundary,
   input wire logic [31:0] cur_pc,
   input wire logic [CPUEX_GEN_N-1:0] gen_req,
   input wire logic gen_is_write,
   input wire logic [7:0] trap_imm,
   input wire logic in_delay_slot,
   input wire logic is_delayed_branch,
   input wire logic rte_exec,
   input wire logic nmi_pin,
   input wire logic [3:0] interrupt_level_inputs,
   input wire logic [CPUEX_PERIPH_N-1:0] periph_req,
   input wire logic periph_first,
   output logic redirect,
   output logic [31:0] redirect_pc,
   output logic retry_branch,
   output logic core_reinit,
   output logic [31:0] status_word,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   import cpuex_pkg::*;

   logic [1:0] nmi_sync;
   logic [3:0] lvl_meta;
   logic [3:0] lvl_sync;
   logic nmi_meta;
   logic [11:0] exception_event_code_reg;
   logic [11:0] interrupt_event_code_reg;
   logic [7:0] trap_immediate_reg;
   logic [31:0] saved_pc;
   logic [31:0] saved_status;
   logic [31:0] vector_base;
   logic [31:0] sample_pc;
   logic gen_any;
   logic [11:0] gen_code;
   logic gen_miss;
   logic gen_completion;
   logic int_any;
   logic [11:0] int_code;
   logic block_bit;
   logic in_pair;
   logic deferred;
   logic [11:0] deferred_code;
   logic deferred_miss;
   logic take_gen;
   logic take_int;
   logic take_deferred;
   logic gen_now;
   logic was_reset;
   logic [7:0] aw_addr;
   logic aw_held;
   logic [31:0] w_data;
   logic [3:0] w_strb;
   logic w_held;
   logic do_write;
   logic sw_wr_status;
   logic [31:0] sw_status;

   cpuex_gen_select u_gen (
      .req(gen_req),
      .is_write(gen_is_write),
      .any(gen_any),
      .code(gen_code),
      .tlb_miss(gen_miss),
      .completion(gen_completion)
   );

   cpuex_int_select u_int (
      .nmi(nmi_sync[1]),
      .interrupt_level_inputs(lvl_sync),
      .periph_req(periph_req),
      .periph_first(periph_first),
      .any(int_any),
      .code(int_code)
   );

   // Pins from outside the core clock
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         nmi_meta <= 1'b0;
         nmi_sync <= 2'b00;
         lvl_meta <= CPUEX_LEVEL_NONE;
         lvl_sync <= CPUEX_LEVEL_NONE;
      end else begin
         nmi_meta <= nmi_pin;
         nmi_sync <= {nmi_sync[0], nmi_meta};
         lvl_meta <= interrupt_level_inputs;
         lvl_sync <= lvl_meta;
      end
   end

   assign block_bit = status_word[CPUEX_SR_BLOCK];
   // Branch and its slot form one unbreakable pair
   assign in_pair = in_delay_slot;
   // Completion-type in branch or slot waits until the branch ran
   assign gen_now = boundary && gen_any && !(gen_completion && (is_delayed_branch || in_delay_slot));
   assign take_deferred = boundary && deferred && !is_delayed_branch && !in_pair;
   assign take_gen = gen_now && !take_deferred;
   assign take_int = boundary && !gen_any && !deferred && int_any && !block_bit && !in_pair
      && !is_delayed_branch;
   // Slot retry restarts at branch, whose pc the pipeline presents
   assign sample_pc = cur_pc;

   // Parked completion-type exception
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         deferred <= 1'b0;
         deferred_code <= 12'h000;
         deferred_miss <= 1'b0;
      end else if (take_deferred) begin
         deferred <= 1'b0;
      end else if (boundary && gen_any && !gen_now && !deferred) begin
         deferred <= 1'b1;
         deferred_code <= gen_code;
         deferred_miss <= gen_miss;
      end
   end

   // Trap immediate captured when the trap instruction executes
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         trap_immediate_reg <= 8'h00;
      end else if (boundary && gen_req[6]) begin
         trap_immediate_reg <= trap_imm;
      end else if (do_write && aw_addr == CPUEX_A_TRAP_IMM && w_strb[0]) begin
         trap_immediate_reg <= w_data[7:0];
      end
   end

   // Core state, saved copies and event codes
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         status_word <= CPUEX_SR_RESET;
         vector_base <= CPUEX_VBR_RESET;
         saved_pc <= 32'h00000000;
         saved_status <= 32'h00000000;
         exception_event_code_reg <= manual_reset ? CPUEX_EV_MANUAL : CPUEX_EV_POWER_ON;
         interrupt_event_code_reg <= 12'h000;
         redirect <= 1'b1;
         redirect_pc <= CPUEX_RESET_VECTOR;
         retry_branch <= 1'b0;
         core_reinit <= 1'b0;
         was_reset <= 1'b1;
      end else begin
         redirect <= 1'b0;
         retry_branch <= 1'b0;
         core_reinit <= 1'b0;
         was_reset <= 1'b0;
         if ((take_gen || take_deferred) && block_bit) begin
            status_word <= CPUEX_SR_RESET;
            vector_base <= CPUEX_VBR_RESET;
            redirect <= 1'b1;
            redirect_pc <= CPUEX_RESET_VECTOR;
            core_reinit <= 1'b1;
         end else if (take_gen || take_deferred) begin
            saved_pc <= sample_pc;
            saved_status <= status_word;
            status_word[CPUEX_SR_PRIV] <= 1'b1;
            status_word[CPUEX_SR_BANK] <= 1'b1;
            status_word[CPUEX_SR_BLOCK] <= 1'b1;
            exception_event_code_reg <= take_deferred ? deferred_code : gen_code;
            redirect <= 1'b1;
            redirect_pc <= vector_base + (((take_deferred ? deferred_miss : gen_miss))
               ? CPUEX_OFS_TLB_MISS : CPUEX_OFS_GENERAL);
            retry_branch <= take_gen && in_delay_slot && !gen_completion;
         end else if (take_int) begin
            saved_pc <= sample_pc;
            saved_status <= status_word;
            status_word[CPUEX_SR_PRIV] <= 1'b1;
            status_word[CPUEX_SR_BANK] <= 1'b1;
            status_word[CPUEX_SR_BLOCK] <= 1'b1;
            interrupt_event_code_reg <= int_code;
            redirect <= 1'b1;
            redirect_pc <= vector_base + CPUEX_OFS_INTERRUPT;
         end else if (boundary && rte_exec) begin
            status_word <= saved_status;
            redirect <= 1'b1;
            redirect_pc <= saved_pc;
         end else if (do_write) begin
            unique case (aw_addr)
               CPUEX_A_EXC_EVENT: exception_event_code_reg <= w_data[11:0];
               CPUEX_A_INT_EVENT: interrupt_event_code_reg <= w_data[11:0];
               CPUEX_A_STATUS: status_word <= w_data;
               CPUEX_A_SAVED_PC: saved_pc <= w_data;
               CPUEX_A_SAVED_ST: saved_status <= w_data;
               CPUEX_A_VBASE: vector_base <= w_data;
               default: ;
            endcase
         end
      end
   end

   // AXI4-Lite write side: address and data in either order
   assign do_write = aw_held && w_held && !s_axi_bvalid;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr <= 8'h00;
         w_data <= 32'h00000000;
         w_strb <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= CPUEX_RESP_OKAY;
      end else begin
         s_axi_awready <= !aw_held && !s_axi_awready && !s_axi_bvalid;
         s_axi_wready <= !w_held && !s_axi_wready && !s_axi_bvalid;
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end
         if (do_write) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (aw_addr[1:0] == 2'b00 && aw_addr <= CPUEX_A_VBASE)
               ? CPUEX_RESP_OKAY : CPUEX_RESP_SLVERR;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // Read side
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= CPUEX_RESP_OKAY;
      end else begin
         s_axi_arready <= !s_axi_arready && !s_axi_rvalid;
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= CPUEX_RESP_OKAY;
            unique case (s_axi_araddr)
               CPUEX_A_TRAP_IMM: s_axi_rdata <= {24'h000000, trap_immediate_reg};
               CPUEX_A_EXC_EVENT: s_axi_rdata <= {20'h00000, exception_event_code_reg};
               CPUEX_A_INT_EVENT: s_axi_rdata <= {20'h00000, interrupt_event_code_reg};
               CPUEX_A_STATUS: s_axi_rdata <= status_word;
               CPUEX_A_SAVED_PC: s_axi_rdata <= saved_pc;
               CPUEX_A_SAVED_ST: s_axi_rdata <= saved_status;
               CPUEX_A_VBASE: s_axi_rdata <= vector_base;
               CPUEX_A_PC: s_axi_rdata <= redirect_pc;
               default: begin
                  s_axi_rdata <= 32'h00000000;
                  s_axi_rresp <= CPUEX_RESP_SLVERR;
               end
            endcase
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // Checks
   sequence s_accept_int;
      take_int ##1 redirect;
   endsequence

   chk_int_vector: assert property (@(posedge aclk) disable iff (!aresetn)
      take_int |=> redirect && redirect_pc == $past(vector_base) + CPUEX_OFS_INTERRUPT)
      else $error("interrupt vector wrong");
   chk_int_blocked: assert property (@(posedge aclk) disable iff (!aresetn)
      block_bit |-> !take_int)
      else $error("interrupt taken while blocked");
   chk_int_sets_bits: assert property (@(posedge aclk) disable iff (!aresetn)
      s_accept_int |-> status_word[CPUEX_SR_BLOCK] && status_word[CPUEX_SR_PRIV] && status_word[CPUEX_SR_BANK]
      && saved_status == $past(status_word))
      else $error("state not saved on accept");
   chk_gen_vector: assert property (@(posedge aclk) disable iff (!aresetn)
      (take_gen && !block_bit && !take_deferred) |=> redirect_pc == $past(vector_base)
      + ($past(gen_miss) ? CPUEX_OFS_TLB_MISS : CPUEX_OFS_GENERAL))
      else $error("exception vector wrong");
   chk_gen_blocked: assert property (@(posedge aclk) disable iff (!aresetn)
      ((take_gen || take_deferred) && block_bit) |=> core_reinit && redirect_pc == CPUEX_RESET_VECTOR)
      else $error("blocked exception not reinit");
   chk_gen_over_int: assert property (@(posedge aclk) disable iff (!aresetn)
      (boundary && gen_any) |-> !take_int)
      else $error("interrupt beat exception");
   chk_no_slot_take: assert property (@(posedge aclk) disable iff (!aresetn)
      in_delay_slot |-> !take_int && !take_deferred)
      else $error("accept inside branch pair");
   chk_rte_restore: assert property (@(posedge aclk) disable iff (!aresetn)
      (boundary && rte_exec && !gen_any && !take_int && !take_deferred) |=>
      status_word == $past(saved_status) && redirect_pc == $past(saved_pc))
      else $error("return restore wrong");
   chk_trap_capture: assert property (@(posedge aclk) disable iff (!aresetn)
      (boundary && gen_req[6]) |=> trap_immediate_reg == $past(trap_imm))
      else $error("trap immediate lost");
   chk_no_reserved: assert property (@(posedge aclk) disable iff (!aresetn)
      exception_event_code_reg != 12'h120 && exception_event_code_reg != 12'h140
      && interrupt_event_code_reg != 12'h3E0 || $past(do_write))
      else $error("reserved code written");
endmodule

// File: cpuex_intc_model.sv
// Purpose: interrupt controller side of the exception block
// Assumes: requests held as levels until the bench drops them
// Notes: ordering between external and peripheral follows want_first, registered again on every clock
module cpuex_intc_model
   import cpuex_pkg::*;
(
   input wire logic aclk,
   input wire logic want_nmi,
   input wire logic [3:0] want_level,
   input wire logic [CPUEX_PERIPH_N-1:0] want_periph,
   input wire logic want_first,
   output logic nmi_pin,
   output logic [3:0] interrupt_level_inputs,
   output logic [CPUEX_PERIPH_N-1:0] periph_req,
   output logic periph_first
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      nmi_pin = 1'b0;
      interrupt_level_inputs = CPUEX_LEVEL_NONE;
      periph_req = '0;
      periph_first = 1'b0;
   end
   always @(posedge aclk) begin
      periph_first <= want_first;
      nmi_pin <= want_nmi;
      interrupt_level_inputs <= want_level;
      periph_req <= want_periph;
   end
endmodule

// File: tb_cpuex_core.sv
// Purpose: self-checking bench of the exception acceptance block
// Assumes: redirect answers one cycle after the taking boundary
// Notes: redirect and read results are queued and checked by a monitor
`define CHK(n, e, s) begin samples_checked++; if ((e) !== (s)) begin miscompares++; \
$display("ERROR %s exp %h got %h", n, e, s); end end
module tb_cpuex_core;
   timeunit 1ns;
   timeprecision 1ps;
   import cpuex_pkg::*;
   logic aclk = 0, aresetn = 0, boundary = 0, wr = 0, slot = 0, br = 0, return_from_exception = 0;
   logic [31:0] pc = 0, status_word, redirect_pc, rdata, wdata = 0, vb, sp;
   logic [CPUEX_GEN_N-1:0] gen = 0;
   logic [7:0] imm = 0, awaddr = 0, araddr = 0;
   logic want_nmi = 0, want_first = 0, manual = 0, nmi_pin, periph_first, redirect, retry_branch, core_reinit;
   logic [3:0] want_level = 4'hF, lvl;
   logic [CPUEX_PERIPH_N-1:0] want_periph = 0, periph;
   logic awvalid = 0, awready, wvalid = 0, wready, bvalid, bready = 0, arvalid = 0, arready, rvalid, rready = 0;
   logic [1:0] bresp, rresp;
   logic [33:0] rdq[$];
   logic [34:0] rq[$];
   logic [31:0] seed = 32'h9B7307F0;
   int miscompares = 0, samples_checked = 0;
   always #2.5 aclk = ~aclk;
   cpuex_intc_model u_cpuex_intc_model (.aclk(aclk), .want_nmi(want_nmi), .want_level(want_level),
      .want_periph(want_periph), .want_first(want_first), .nmi_pin(nmi_pin), .interrupt_level_inputs(lvl),
      .periph_req(periph), .periph_first(periph_first));
   cpuex_core u_cpuex_core (.aclk(aclk), .aresetn(aresetn), .manual_reset(manual), .boundary(boundary),
      .cur_pc(pc), .gen_req(gen), .gen_is_write(wr), .trap_imm(imm), .in_delay_slot(slot),
      .is_delayed_branch(br), .rte_exec(return_from_exception), .nmi_pin(nmi_pin), .interrupt_level_inputs(lvl),
      .periph_req(periph), .periph_first(periph_first), .redirect(redirect), .redirect_pc(redirect_pc),
      .retry_branch(retry_branch), .core_reinit(core_reinit), .status_word(status_word),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready));
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   function automatic logic [11:0] gcode(int i, logic w);
      case (i)
         0: return CPUEX_EV_ADDR_LOAD;
         1, 2, 8, 9: return w ? CPUEX_EV_TLB_STORE : CPUEX_EV_TLB_LOAD;
         3: return CPUEX_EV_PROT_LOAD;
         4: return CPUEX_EV_RESERVED_OP;
         5: return CPUEX_EV_ILLEGAL_SLOT;
         6: return CPUEX_EV_TRAP;
         7: return w ? CPUEX_EV_ADDR_STORE : CPUEX_EV_ADDR_LOAD;
         10: return w ? CPUEX_EV_PROT_STORE : CPUEX_EV_PROT_LOAD;
         11: return CPUEX_EV_PAGE_WRITE;
         default: return CPUEX_EV_USER_BREAK;
      endcase
   endfunction
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      forever begin
         @(posedge aclk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid) begin
            bready <= 1'b0;
            break;
         end
      end
   endtask
   task automatic axi_rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
      rdq.push_back({r, e});
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      forever begin
         @(posedge aclk);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid) begin
            rready <= 1'b0;
            break;
         end
      end
   endtask
   // One boundary; expected redirect, if any, is queued by the caller
   task automatic op(input int g, input logic s, input logic b, input logic r);
      @(posedge aclk);
      boundary <= 1'b1;
      gen <= (g < 0) ? '0 : CPUEX_GEN_N'(1) << g;
      slot <= s;
      br <= b;
      return_from_exception <= r;
      @(posedge aclk);
      boundary <= 1'b0;
      gen <= '0;
      repeat (3) @(posedge aclk);
   endtask
   task automatic unblock();
      axi_wr(CPUEX_A_STATUS, 32'h0);
   endtask
   always @(posedge aclk) begin
      if (aresetn && redirect) begin
         if (rq.size() == 0) `CHK("redirect", 1'b0, redirect)
         else `CHK("redirect", rq.pop_front(), {retry_branch, core_reinit, 1'b1, redirect_pc})
      end
      if (rvalid && rready) begin
         if (rdq[0][33:32] === CPUEX_RESP_OKAY) `CHK("rdata", rdq[0], {rresp, rdata})
         else `CHK("rresp", rdq[0][33:32], rresp)
         void'(rdq.pop_front());
      end
   end
   task automatic print_verdict();
      if (miscompares == 0 && samples_checked > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   initial begin
      #100000;
      miscompares++;
      print_verdict();
   end
   initial begin
      rq.push_back({3'b001, CPUEX_RESET_VECTOR});
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      `CHK("status", CPUEX_SR_RESET, status_word)
      axi_rd(CPUEX_A_EXC_EVENT, {20'h0, CPUEX_EV_POWER_ON}, CPUEX_RESP_OKAY);
      vb = rnd() & 32'hFFFFF000;
      axi_wr(CPUEX_A_VBASE, vb);
      for (int i = 0; i < CPUEX_GEN_N; i++) begin
         unblock();
         pc <= rnd() & 32'hFFFFFFFE;
         wr <= (i > 6) ? 1'(rnd()) : 1'b0;
         imm <= 8'(rnd());
         rq.push_back({3'b001, vb + ((i == 1 || i == 8) ? CPUEX_OFS_TLB_MISS : CPUEX_OFS_GENERAL)});
         op(i, 0, 0, 0);
         `CHK("block", 3'b111, status_word[30:28])
         axi_rd(CPUEX_A_EXC_EVENT, {20'h0, gcode(i, wr)}, CPUEX_RESP_OKAY);
         axi_rd(CPUEX_A_SAVED_PC, pc, CPUEX_RESP_OKAY);
         if (i == 6) axi_rd(CPUEX_A_TRAP_IMM, {24'h0, imm}, CPUEX_RESP_OKAY);
      end
      rq.push_back({3'b011, CPUEX_RESET_VECTOR});
      op(4, 0, 0, 0);
      // Reinit also clears the vector base, so software sets it again
      axi_rd(CPUEX_A_VBASE, CPUEX_VBR_RESET, CPUEX_RESP_OKAY);
      axi_wr(CPUEX_A_VBASE, vb);
      unblock();
      want_nmi <= 1'b1;
      want_level <= 4'h5;
      repeat (4) @(posedge aclk);
      rq.push_back({3'b001, vb + CPUEX_OFS_INTERRUPT});
      op(-1, 0, 0, 0);
      want_nmi <= 1'b0;
      axi_rd(CPUEX_A_INT_EVENT, {20'h0, CPUEX_EV_NMI}, CPUEX_RESP_OKAY);
      op(-1, 0, 0, 0);
      unblock();
      op(-1, 1, 0, 0);
      rq.push_back({3'b001, vb + CPUEX_OFS_INTERRUPT});
      op(-1, 0, 0, 0);
      axi_rd(CPUEX_A_INT_EVENT, {20'h0, 12'h2A0}, CPUEX_RESP_OKAY);
      for (int f = 1; f >= 0; f--) begin
         unblock();
         want_first <= f[0];
         want_periph <= CPUEX_PERIPH_N'(1);
         repeat (4) @(posedge aclk);
         rq.push_back({3'b001, vb + CPUEX_OFS_INTERRUPT});
         op(-1, 0, 0, 0);
         axi_rd(CPUEX_A_INT_EVENT, {20'h0, f ? CPUEX_EV_PERIPH_BASE : 12'h2A0}, CPUEX_RESP_OKAY);
      end
      want_periph <= '0;
      want_level <= 4'hF;
      unblock();
      repeat (4) @(posedge aclk);
      op(-1, 0, 0, 0);
      for (int i = 0; i < CPUEX_PERIPH_N; i++) begin
         want_periph <= CPUEX_PERIPH_N'(1) << i;
         repeat (4) @(posedge aclk);
         rq.push_back({3'b001, vb + CPUEX_OFS_INTERRUPT});
         op(-1, 0, 0, 0);
         want_periph <= '0;
         axi_rd(CPUEX_A_INT_EVENT, {20'h0, 12'h400 + 12'(i * 32)}, CPUEX_RESP_OKAY);
         unblock();
      end
      rq.push_back({3'b101, vb + CPUEX_OFS_GENERAL});
      op(4, 1, 0, 0);
      unblock();
      op(6, 0, 1, 0);
      op(-1, 1, 0, 0);
      rq.push_back({3'b001, vb + CPUEX_OFS_GENERAL});
      op(-1, 0, 0, 0);
      sp = rnd() & 32'hFFFFFFFE;
      axi_wr(CPUEX_A_SAVED_PC, sp);
      axi_wr(CPUEX_A_SAVED_ST, 32'h0);
      rq.push_back({3'b001, sp});
      op(-1, 0, 0, 1);
      `CHK("status", 32'h0, status_word)
      axi_rd(8'h20, 32'h0, CPUEX_RESP_SLVERR);
      // Second reset in mid-run, this time of the manual kind
      manual <= 1'b1;
      aresetn <= 1'b0;
      rq.push_back({3'b001, CPUEX_RESET_VECTOR});
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      axi_rd(CPUEX_A_EXC_EVENT, {20'h0, CPUEX_EV_MANUAL}, CPUEX_RESP_OKAY);
      repeat (4) @(posedge aclk);
      `CHK("queues", 0, rq.size() + rdq.size())
      print_verdict();
   end
endmodule
